//--- emc_pkg.sv
// Constants, register map and types for the edge measure / up-down count block
// Assumes a plain register port with one-cycle strobes and read data one cycle later
//
// Operation
// - Mode 0x15: bus 0, rotation measure, rising
// - Each edge copies off-duty count to capture
// - Edge counter increments per effective edge
// - Capture data reads edge counter in rotation
// - Interval compare match sets overflow flag
// - 16-bit compare zero-extended against 32-bit counter
// - Each edge captures timing counter as cycle
// - Each edge accumulates timing counter into total
// - Interval match raises overflow interrupt
// - Enable 0x08 gates overflow interrupt request
// - Clear 0x08 clears overflow, 0x0F all
// - Start 0x800 runs sb4, 0x001 sb0
// - Prescaler n divides clock by n+1
// - Unit enable 0x41 enables prescaler and count
// - Up/down counts counted edges by direction level
// - Period counter counts bus, compared to period
// - Period match captures up/down count
// - Mode 0x1B: bus 0, up/down, both edges
// - Period 0xFF gives 255 bus cycles
// - Period end saves and clears up/down count
// - Enable 0x01 gives match irq; clear 0x01
package emc_pkg;
    // Register addresses
    localparam logic [7:0] A_UNIT_ENABLE = 8'h00;
    localparam logic [7:0] A_PRESCALER = 8'h04;
    localparam logic [7:0] A_START = 8'h08;
    localparam logic [7:0] A_MODE_SB0 = 8'h10;
    localparam logic [7:0] A_IRQ_EN_SB0 = 8'h14;
    localparam logic [7:0] A_STATUS_SB0 = 8'h18;
    localparam logic [7:0] A_CLEAR_SB0 = 8'h1C;
    localparam logic [7:0] A_PERIOD_CMP = 8'h20;
    localparam logic [7:0] A_UPDOWN_CAP = 8'h24;
    localparam logic [7:0] A_PERIOD_CNT = 8'h28;
    localparam logic [7:0] A_UPDOWN_CNT = 8'h2C;
    localparam logic [7:0] A_MODE_SB4 = 8'h40;
    localparam logic [7:0] A_IRQ_EN_SB4 = 8'h44;
    localparam logic [7:0] A_STATUS_SB4 = 8'h48;
    localparam logic [7:0] A_CLEAR_SB4 = 8'h4C;
    localparam logic [7:0] A_OFFDUTY_CAP = 8'h50;
    localparam logic [7:0] A_INTERVAL_CMP = 8'h54;
    localparam logic [7:0] A_CYCLE_CAP = 8'h58;
    localparam logic [7:0] A_ACCUM_TIME = 8'h5C;
    localparam logic [7:0] A_CAPTURE_DATA_SB4 = 8'h60;
    // Mode codes and bit positions
    localparam logic [7:0] MODE_ROTATION = 8'h15;
    localparam logic [7:0] MODE_UPDOWN = 8'h1B;
    localparam int UE_PRESCALER_BIT = 0;
    localparam int UE_TIMER_BIT = 6;
    localparam int START_SB0_BIT = 0;
    localparam int START_SB4_BIT = 11;
    localparam int FLAG_MATCH_BIT = 0;
    localparam int FLAG_OVF_BIT = 3;
    localparam logic [3:0] FLAG_MASK = 4'hF;
    localparam logic [15:0] PSC_RESET = 16'h0000;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    localparam logic [31:0] ONE32 = 32'h0000_0001;

    // Mode of the sub-block decoded from its mode control
    typedef enum logic [1:0] {
        EMC_MODE_IDLE = 2'b00,
        EMC_MODE_ROT = 2'b01,
        EMC_MODE_UD = 2'b10
    } emc_mode_t;
endpackage : emc_pkg

//--- emc_sync.sv
// Three-flop input synchroniser with agreement filter
// Assumes an asynchronous pin input
`timescale 1ns/10ps
module emc_sync
    import emc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic pin,
    output logic level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } emc_sync_st_t;
    emc_sync_st_t st_r, st_nxt;

    // Shift chain; level follows once second and third agree
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pin;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        if (st_r.s2 == st_r.s3) begin
            st_nxt.lvl = st_r.s3;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level = st_r.lvl;
endmodule : emc_sync

//--- emc_prescaler.sv
// Prescaler producing the clock bus 0 tick
// Assumes a divider setting from the register file
`timescale 1ns/10ps
module emc_prescaler
    import emc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic [15:0] divider,
    output logic tick
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
        logic [16:0] gap; // Clocks since the previous tick
        logic gap_ok; // Divider and enable held over the whole gap
        logic [15:0] div_prev;
    } emc_psc_st_t;
    emc_psc_st_t st_r, st_nxt;

    // One tick every divider+1 clocks; gap fields only feed the spacing check
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        st_nxt.div_prev = divider;
        if (st_r.tick) begin
            st_nxt.gap = 17'h00001;
            st_nxt.gap_ok = (divider == st_r.div_prev) && enable;
        end else begin
            st_nxt.gap = st_r.gap + 17'h00001;
            st_nxt.gap_ok = st_r.gap_ok && (divider == st_r.div_prev) && enable;
        end
        if (!enable) begin
            st_nxt.cnt = PSC_RESET;
        end else if (st_r.cnt >= divider) begin
            st_nxt.cnt = PSC_RESET;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;

    a_tick_spacing: assert property (@(posedge sys_clk) disable iff (rst)
        tick && st_r.gap_ok |-> st_r.gap == {1'b0, st_r.div_prev} + 17'h00001)
        else $error("prescaler tick spacing wrong");
endmodule : emc_prescaler

//--- emc_top.sv
// Edge measure (sub-block 4) and up/down count (sub-block 0) with register port
// Assumes synchronous register master; pins asynchronous to sys_clk
`timescale 1ns/10ps
module emc_top
    import emc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic measured_input,
    input wire logic counted_input,
    input wire logic direction_input,
    output logic overflow_interrupt,
    output logic match_interrupt
);
    typedef struct packed {
        logic [7:0] unit_enable;
        logic [15:0] prescaler_divider;
        logic [31:0] subblock_start;
        logic [7:0] mode_control_sb0;
        logic [7:0] irq_enable_sb0;
        logic [3:0] flag_status_sb0;
        logic [31:0] period_compare;
        logic [31:0] updown_capture;
        logic [31:0] period_counter;
        logic [31:0] updown_counter;
        logic [7:0] mode_control_sb4;
        logic [7:0] irq_enable_sb4;
        logic [3:0] flag_status_sb4;
        logic [31:0] offduty_counter;
        logic [31:0] edge_counter;
        logic [31:0] edge_timing_counter;
        logic [31:0] offduty_capture;
        logic [15:0] edge_interval_compare;
        logic [31:0] cycle_capture;
        logic [31:0] accumulated_time;
        logic meas_prev;
        logic cnt_prev;
        logic run4_prev;
        logic run0_prev;
        logic [31:0] rdata;
    } emc_st_t;
    emc_st_t st_r, st_nxt;

    logic meas_lvl, cnt_lvl, dir_lvl, bus_tick;
    logic run4, run0, edge4, edge0, ovf_hit, per_hit;
    emc_mode_t mode4, mode0;

    // ------------------------------------------------------------
    // Input synchronisers and prescaler
    // ------------------------------------------------------------
    emc_sync u_sync_meas (.sys_clk(sys_clk), .rst(rst), .pin(measured_input), .level(meas_lvl));
    emc_sync u_sync_cnt (.sys_clk(sys_clk), .rst(rst), .pin(counted_input), .level(cnt_lvl));
    emc_sync u_sync_dir (.sys_clk(sys_clk), .rst(rst), .pin(direction_input), .level(dir_lvl));
    emc_prescaler u_psc (
        .sys_clk(sys_clk),
        .rst(rst),
        .enable(st_r.unit_enable[UE_PRESCALER_BIT]),
        .divider(st_r.prescaler_divider),
        .tick(bus_tick)
    );

    // Mode decode from the mode control byte
    function automatic emc_mode_t decode_mode(input logic [7:0] m);
        if (m == MODE_ROTATION) begin
            decode_mode = EMC_MODE_ROT;
        end else if (m == MODE_UPDOWN) begin
            decode_mode = EMC_MODE_UD;
        end else begin
            decode_mode = EMC_MODE_IDLE;
        end
    endfunction : decode_mode

    // Write-one-to-clear with set winning
    function automatic logic [3:0] flag_upd(input logic [3:0] f, input logic [3:0] clr, input logic [3:0] set);
        flag_upd = (f & ~clr) | set;
    endfunction : flag_upd

    // ------------------------------------------------------------
    // Event decode
    // ------------------------------------------------------------
    always_comb begin
        mode4 = decode_mode(st_r.mode_control_sb4);
        mode0 = decode_mode(st_r.mode_control_sb0);
        run4 = st_r.unit_enable[UE_TIMER_BIT] && st_r.subblock_start[START_SB4_BIT];
        run0 = st_r.unit_enable[UE_TIMER_BIT] && st_r.subblock_start[START_SB0_BIT];
        edge4 = run4 && (mode4 == EMC_MODE_ROT) && meas_lvl && !st_r.meas_prev;
        edge0 = run0 && (mode0 == EMC_MODE_UD) && (cnt_lvl != st_r.cnt_prev);
        ovf_hit = run4 && (mode4 == EMC_MODE_ROT)
            && (st_r.edge_timing_counter == {16'h0000, st_r.edge_interval_compare});
        // Period closes on the compare-th tick, so compare value equals period length
        per_hit = run0 && (mode0 == EMC_MODE_UD) && bus_tick
            && (st_r.period_counter + ONE32 == st_r.period_compare);
    end

    // ------------------------------------------------------------
    // State update: counters, captures, registers, read data
    // ------------------------------------------------------------
    always_comb begin
        logic [3:0] clr4;
        logic [3:0] clr0;
        logic [3:0] set4;
        logic [3:0] set0;
        clr4 = 4'h0;
        clr0 = 4'h0;
        set4 = 4'h0;
        set0 = 4'h0;
        st_nxt = st_r;
        st_nxt.meas_prev = meas_lvl;
        st_nxt.cnt_prev = cnt_lvl;
        st_nxt.run4_prev = run4;
        st_nxt.run0_prev = run0;
        st_nxt.rdata = ZERO32;

        // Sub-block 4 rotation speed / pulse measurement
        if (run4 && !st_r.run4_prev) begin
            st_nxt.offduty_counter = ZERO32;
            st_nxt.edge_counter = ZERO32;
            st_nxt.edge_timing_counter = ZERO32;
            st_nxt.accumulated_time = ZERO32;
        end else if (run4 && mode4 == EMC_MODE_ROT) begin
            if (bus_tick) begin
                st_nxt.edge_timing_counter = st_r.edge_timing_counter + ONE32;
                if (!meas_lvl) begin
                    st_nxt.offduty_counter = st_r.offduty_counter + ONE32;
                end
            end
            if (edge4) begin
                st_nxt.edge_counter = st_r.edge_counter + ONE32;
                st_nxt.offduty_capture = st_r.offduty_counter;
                st_nxt.cycle_capture = st_r.edge_timing_counter;
                st_nxt.accumulated_time = st_r.accumulated_time + st_r.edge_timing_counter;
                st_nxt.edge_timing_counter = ZERO32;
                st_nxt.offduty_counter = ZERO32;
            end
        end
        if (ovf_hit) begin
            set4[FLAG_OVF_BIT] = 1'b1;
        end

        // Sub-block 0 up/down event count
        if (run0 && !st_r.run0_prev) begin
            st_nxt.period_counter = ZERO32;
            st_nxt.updown_counter = ZERO32;
        end else if (run0 && mode0 == EMC_MODE_UD) begin
            if (per_hit) begin
                st_nxt.period_counter = ZERO32;
            end else if (bus_tick) begin
                st_nxt.period_counter = st_r.period_counter + ONE32;
            end
            if (per_hit) begin
                st_nxt.updown_capture = st_r.updown_counter;
                st_nxt.updown_counter = ZERO32;
                set0[FLAG_MATCH_BIT] = 1'b1;
            end else if (edge0 && dir_lvl) begin
                st_nxt.updown_counter = st_r.updown_counter + ONE32;
            end else if (edge0) begin
                st_nxt.updown_counter = st_r.updown_counter - ONE32;
            end
        end

        // Register writes
        if (reg_wr) begin
            if (reg_addr == A_UNIT_ENABLE) begin
                st_nxt.unit_enable = reg_wdata[7:0];
            end else if (reg_addr == A_PRESCALER) begin
                st_nxt.prescaler_divider = reg_wdata[15:0];
            end else if (reg_addr == A_START) begin
                st_nxt.subblock_start = reg_wdata;
            end else if (reg_addr == A_MODE_SB0) begin
                st_nxt.mode_control_sb0 = reg_wdata[7:0];
            end else if (reg_addr == A_IRQ_EN_SB0) begin
                st_nxt.irq_enable_sb0 = reg_wdata[7:0];
            end else if (reg_addr == A_CLEAR_SB0) begin
                clr0 = reg_wdata[3:0] & FLAG_MASK;
            end else if (reg_addr == A_PERIOD_CMP) begin
                st_nxt.period_compare = reg_wdata;
            end else if (reg_addr == A_MODE_SB4) begin
                st_nxt.mode_control_sb4 = reg_wdata[7:0];
            end else if (reg_addr == A_IRQ_EN_SB4) begin
                st_nxt.irq_enable_sb4 = reg_wdata[7:0];
            end else if (reg_addr == A_CLEAR_SB4) begin
                clr4 = reg_wdata[3:0] & FLAG_MASK;
            end else if (reg_addr == A_INTERVAL_CMP) begin
                st_nxt.edge_interval_compare = reg_wdata[15:0];
            end
        end
        st_nxt.flag_status_sb4 = flag_upd(st_r.flag_status_sb4, clr4, set4);
        st_nxt.flag_status_sb0 = flag_upd(st_r.flag_status_sb0, clr0, set0);

        // Register reads, answered next cycle
        if (reg_rd) begin
            if (reg_addr == A_UNIT_ENABLE) begin
                st_nxt.rdata = {24'h000000, st_r.unit_enable};
            end else if (reg_addr == A_PRESCALER) begin
                st_nxt.rdata = {16'h0000, st_r.prescaler_divider};
            end else if (reg_addr == A_START) begin
                st_nxt.rdata = st_r.subblock_start;
            end else if (reg_addr == A_MODE_SB0) begin
                st_nxt.rdata = {24'h000000, st_r.mode_control_sb0};
            end else if (reg_addr == A_IRQ_EN_SB0) begin
                st_nxt.rdata = {24'h000000, st_r.irq_enable_sb0};
            end else if (reg_addr == A_STATUS_SB0) begin
                st_nxt.rdata = {28'h0000000, st_r.flag_status_sb0};
            end else if (reg_addr == A_PERIOD_CMP) begin
                st_nxt.rdata = st_r.period_compare;
            end else if (reg_addr == A_UPDOWN_CAP) begin
                st_nxt.rdata = st_r.updown_capture;
            end else if (reg_addr == A_PERIOD_CNT) begin
                st_nxt.rdata = st_r.period_counter;
            end else if (reg_addr == A_UPDOWN_CNT) begin
                st_nxt.rdata = st_r.updown_counter;
            end else if (reg_addr == A_MODE_SB4) begin
                st_nxt.rdata = {24'h000000, st_r.mode_control_sb4};
            end else if (reg_addr == A_IRQ_EN_SB4) begin
                st_nxt.rdata = {24'h000000, st_r.irq_enable_sb4};
            end else if (reg_addr == A_STATUS_SB4) begin
                st_nxt.rdata = {28'h0000000, st_r.flag_status_sb4};
            end else if (reg_addr == A_OFFDUTY_CAP) begin
                st_nxt.rdata = st_r.offduty_capture;
            end else if (reg_addr == A_INTERVAL_CMP) begin
                st_nxt.rdata = {16'h0000, st_r.edge_interval_compare};
            end else if (reg_addr == A_CYCLE_CAP) begin
                st_nxt.rdata = st_r.cycle_capture;
            end else if (reg_addr == A_ACCUM_TIME) begin
                st_nxt.rdata = st_r.accumulated_time;
            end else if (reg_addr == A_CAPTURE_DATA_SB4) begin
                st_nxt.rdata = (mode4 == EMC_MODE_ROT) ? st_r.edge_counter : ZERO32;
            end else begin
                st_nxt.rdata = ZERO32;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata = st_r.rdata;
    assign overflow_interrupt = st_r.flag_status_sb4[FLAG_OVF_BIT] && st_r.irq_enable_sb4[FLAG_OVF_BIT];
    assign match_interrupt = st_r.flag_status_sb0[FLAG_MATCH_BIT] && st_r.irq_enable_sb0[FLAG_MATCH_BIT];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_offduty_copy: assert property (@(posedge sys_clk) disable iff (rst)
        edge4 && !(run4 && !st_r.run4_prev) |=> st_r.offduty_capture == $past(st_r.offduty_counter))
        else $error("off-duty capture missed");
    a_edge_count: assert property (@(posedge sys_clk) disable iff (rst)
        edge4 && st_r.run4_prev |=> st_r.edge_counter == $past(st_r.edge_counter) + ONE32)
        else $error("edge counter did not step");
    a_capdata_read: assert property (@(posedge sys_clk) disable iff (rst)
        reg_rd && reg_addr == A_CAPTURE_DATA_SB4 && mode4 == EMC_MODE_ROT
        |=> reg_rdata == $past(st_r.edge_counter))
        else $error("capture data read wrong");
    a_ovf_flag: assert property (@(posedge sys_clk) disable iff (rst)
        ovf_hit |=> st_r.flag_status_sb4[FLAG_OVF_BIT])
        else $error("overflow flag not set");
    a_cycle_copy: assert property (@(posedge sys_clk) disable iff (rst)
        edge4 && st_r.run4_prev |=> st_r.cycle_capture == $past(st_r.edge_timing_counter))
        else $error("cycle capture missed");
    a_accum_add: assert property (@(posedge sys_clk) disable iff (rst)
        edge4 && st_r.run4_prev
        |=> st_r.accumulated_time == $past(st_r.accumulated_time) + $past(st_r.edge_timing_counter))
        else $error("accumulation wrong");
    a_ovf_gate: assert property (@(posedge sys_clk) disable iff (rst)
        ovf_hit |=> overflow_interrupt == st_r.irq_enable_sb4[FLAG_OVF_BIT])
        else $error("overflow irq not gated by enable");
    a_run_gate: assert property (@(posedge sys_clk) disable iff (rst)
        !run4 |=> st_r.edge_counter == $past(st_r.edge_counter))
        else $error("edge counter moved while stopped");
    a_ud_up: assert property (@(posedge sys_clk) disable iff (rst)
        edge0 && dir_lvl && !per_hit && st_r.run0_prev
        |=> st_r.updown_counter == $past(st_r.updown_counter) + ONE32)
        else $error("up count missed");
    a_ud_down: assert property (@(posedge sys_clk) disable iff (rst)
        edge0 && !dir_lvl && !per_hit && st_r.run0_prev
        |=> st_r.updown_counter == $past(st_r.updown_counter) - ONE32)
        else $error("down count missed");
    a_period_wrap: assert property (@(posedge sys_clk) disable iff (rst)
        per_hit && st_r.run0_prev |=> st_r.period_counter == ZERO32)
        else $error("period counter not restarted");
    a_clear_all: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == A_CLEAR_SB4 && reg_wdata[3:0] == FLAG_MASK && !ovf_hit
        |=> st_r.flag_status_sb4 == 4'h0)
        else $error("flag clear failed");
    a_ud_capture: assert property (@(posedge sys_clk) disable iff (rst)
        per_hit && st_r.run0_prev
        |=> st_r.updown_capture == $past(st_r.updown_counter) && st_r.updown_counter == ZERO32)
        else $error("up/down capture wrong");
    a_match_irq: assert property (@(posedge sys_clk) disable iff (rst)
        per_hit && st_r.run0_prev && st_r.irq_enable_sb0[FLAG_MATCH_BIT] |=> match_interrupt)
        else $error("match irq missing");
    a_start_zero: assert property (@(posedge sys_clk) disable iff (rst)
        run4 && !st_r.run4_prev |=> st_r.edge_counter == ZERO32 && st_r.accumulated_time == ZERO32)
        else $error("counters not zeroed at start");
endmodule : emc_top

//--- emc_pulse_src.sv
// Behavioural model of the external pulse sources feeding the block
// Assumes the bench calls its tasks; pins change just after a rising edge
`timescale 1ns/10ps
module emc_pulse_src (
    input wire logic sys_clk,
    output logic measured_input,
    output logic counted_input,
    output logic direction_input
);
    longint last_rise;
    longint last_period;

    // Idle levels at time zero
    initial begin
        measured_input = 1'b0;
        counted_input = 1'b0;
        direction_input = 1'b0;
        last_rise = 0;
        last_period = 0;
    end

    // ----------------------------------------
    // Rotation sensor: low phase, rising edge, high phase
    // ----------------------------------------
    task automatic rise_pulse(input int low_cyc, input int high_cyc);
        @(posedge sys_clk);
        measured_input <= 1'b0;
        repeat (low_cyc) @(posedge sys_clk);
        measured_input <= 1'b1;
        last_period = ($time - last_rise) / 10; // Cycles since previous rise
        last_rise = $time;
        repeat (high_cyc) @(posedge sys_clk);
    endtask : rise_pulse

    // ----------------------------------------
    // Encoder: set direction, then toggle the counted pin n times
    // ----------------------------------------
    task automatic ud_edges(input logic up, input int n);
        @(posedge sys_clk);
        direction_input <= up;
        repeat (6) @(posedge sys_clk); // Level settles before any edge
        for (int i = 0; i < n; i++) begin
            counted_input <= ~counted_input;
            repeat (6) @(posedge sys_clk); // Keeps pins stable over 6 cycles
        end
    endtask : ud_edges
endmodule : emc_pulse_src

//--- edge_measure_updown_count_tb.sv
// Self-checking bench for the edge measure / up-down count block
// Assumes emc_pkg, emc_top and emc_pulse_src are compiled first
`timescale 1ns/10ps
module edge_measure_updown_count_tb;
    import emc_pkg::*;
    logic sys_clk, rst, reg_wr, reg_rd;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d, acc;
    logic measured_input, counted_input, direction_input, overflow_interrupt, match_interrupt;
    int mismatches, checks_done;
    longint t1, t2;

    emc_top emc_top_i (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .measured_input(measured_input),
        .counted_input(counted_input), .direction_input(direction_input),
        .overflow_interrupt(overflow_interrupt), .match_interrupt(match_interrupt));
    emc_pulse_src emc_pulse_src_i (.sys_clk(sys_clk), .measured_input(measured_input),
        .counted_input(counted_input), .direction_input(direction_input));

    // 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // Register port and comparison tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata; // Data stands only in this cycle
    endtask : rd

    task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        checks_done++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask : chk

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    // Bounded wait for the compare match interrupt, returns its time
    task automatic wait_match(output longint t);
        for (int i = 0; i < 14000; i++) begin
            @(posedge sys_clk);
            #1;
            if (match_interrupt === 1'b1) begin
                t = $time;
                return;
            end
        end
        mismatches++;
        $display("[ERR] %0t match interrupt never came", $time);
        print_verdict();
    endtask : wait_match

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        mismatches = 0;
        checks_done = 0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        // Reset values and an unmapped read
        rd(A_CAPTURE_DATA_SB4, d);
        chk(d, ZERO32, ZERO32);
        rd(8'hFC, d);
        chk(d, ZERO32, ZERO32);
        // Rotation measurement on an undivided bus
        wr(A_UNIT_ENABLE, 32'h0000_0041);
        wr(A_PRESCALER, 32'h0000_0000);
        wr(A_MODE_SB4, {24'h00_0000, MODE_ROTATION});
        wr(A_INTERVAL_CMP, 32'h0000_FFFF);
        wr(A_CLEAR_SB4, 32'h0000_000F);
        wr(A_START, 32'h0000_0800);
        for (int i = 0; i < 4; i++) emc_pulse_src_i.rise_pulse(20, 20);
        rd(A_CAPTURE_DATA_SB4, d);
        chk(d, 32'h0000_0004, 32'h0000_0004);
        rd(A_ACCUM_TIME, acc);
        emc_pulse_src_i.rise_pulse(15, 25);
        rd(A_CYCLE_CAP, d);
        chk(d, emc_pulse_src_i.last_period - 1, emc_pulse_src_i.last_period);
        rd(A_OFFDUTY_CAP, d);
        chk(d, 32'h0000_000E, 32'h0000_0010);
        rd(A_ACCUM_TIME, d);
        chk(d - acc, emc_pulse_src_i.last_period - 1, emc_pulse_src_i.last_period);
        // Interval overflow: upper half of the written value must be dropped
        wr(A_IRQ_EN_SB4, 32'h0000_0000);
        wr(A_INTERVAL_CMP, 32'h0001_0010);
        emc_pulse_src_i.rise_pulse(10, 40);
        rd(A_STATUS_SB4, d);
        chk(d & 32'h0000_0008, 32'h0000_0008, 32'h0000_0008);
        chk({31'h0, overflow_interrupt}, ZERO32, ZERO32);
        wr(A_IRQ_EN_SB4, 32'h0000_0008);
        @(posedge sys_clk);
        #1 chk({31'h0, overflow_interrupt}, ONE32, ONE32);
        wr(A_CLEAR_SB4, 32'h0000_0008);
        @(posedge sys_clk);
        #1 chk({31'h0, overflow_interrupt}, ZERO32, ZERO32);
        rd(A_STATUS_SB4, d);
        chk(d & 32'h0000_0008, ZERO32, ZERO32);
        // Up/down counting, bus divided by fifty, period compare 0xFF
        wr(A_START, 32'h0000_0001);
        wr(A_PRESCALER, 32'h0000_0031);
        wr(A_MODE_SB0, {24'h00_0000, MODE_UPDOWN});
        wr(A_PERIOD_CMP, 32'h0000_00FF);
        wr(A_IRQ_EN_SB0, 32'h0000_0001);
        wait_match(t1);
        wr(A_CLEAR_SB0, 32'h0000_0001);
        emc_pulse_src_i.ud_edges(1'b1, 6);
        emc_pulse_src_i.ud_edges(1'b0, 2);
        wait_match(t2);
        chk(32'((t2 - t1) / 10), 32'd12750, 32'd12750);
        wr(A_CLEAR_SB0, 32'h0000_0001);
        rd(A_UPDOWN_CAP, d);
        chk(d, 32'h0000_0004, 32'h0000_0004);
        rd(A_UPDOWN_CNT, d);
        chk(d, ZERO32, ZERO32);
        emc_pulse_src_i.ud_edges(1'b0, 3);
        wait_match(t1);
        rd(A_UPDOWN_CAP, d);
        chk(d, 32'hFFFF_FFFD, 32'hFFFF_FFFD);
        print_verdict();
    end
endmodule : edge_measure_updown_count_tb
